//--- twe_pkg.sv
/*
 * Shared constants and types for the two-wire serial memory link:
 * timing, field positions, the device address and the host command set.
 * Assumes both ends and the bench refer to it by scoped name only.
 */
// How it works
// - sample on clock rise, change after fall
// - data line only ever pulled low
// - 128 bytes, one address byte
// - master starts idle, data steady while clock high
// - data change with clock high is condition
// - falling data, clock high, means start
// - rising data, clock high, means stop, standby
// - eight-bit words, ninth clock acknowledges
// - device address 1010 000 first
// - last address bit high means read
// - match acknowledges, mismatch returns to standby
// - byte write: device, word address, data, stop
// - stop after write starts timed programming
// - master polls until address is acknowledged
// - current, random and sequential reads supported
// - counter holds last address plus one
// - read counter wraps over whole array
// - write counter wraps inside its page
// - current read sends byte, master nacks, stops
// - random read uses dummy write, restart
// - master ack advances counter, next byte
// - master ends read with nack, stop
package twe_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int WORDS = 128;
    localparam int PAGE_W = 3;
    localparam int WR_CYCLES = 1000;
    localparam logic [6:0] DEV_ID = 7'h50;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] ACK_END = 4'h9;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam int CLK_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
    // quarter phases of one serial clock period on the host
    localparam logic [1:0] PH_LOW = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_MID = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;
    typedef enum logic [1:0] {OP_WRITE, OP_CUR_RD, OP_RND_RD, OP_POLL} twe_op_e;
endpackage

//--- twe_link_if.sv
/*
 * Two-wire link between host and memory end.
 * Assumes an external pull-up: the data line is high unless an end pulls it.
 */
`timescale 1ns/1ps
interface twe_link_if;
    logic scl;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic sda;

    // wired-and of both open-drain drivers with the pull-up
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

    modport host (
        output scl,
        output sda_h_o,
        output sda_h_oe,
        input sda
    );
    modport dev (
        input scl,
        input sda,
        output sda_d_o,
        output sda_d_oe
    );
endinterface

//--- twe_dev.sv
/*
 * Memory end of the two-wire link: condition detection, device address
 * match, byte write with timed programming, reads through the counter.
 * Assumes link_clk_i oversamples the serial clock at least four times
 * per quarter period; the bus wires arrive asynchronously.
 */
`timescale 1ns/1ps
module twe_dev #(
    parameter int PAGE_W = twe_pkg::PAGE_W,
    parameter int WR_CYCLES = twe_pkg::WR_CYCLES
) (
    // clock, reset, enable
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // serial bus
    twe_link_if.dev link,
    // status
    output logic busy_o,
    output logic standby_o
);
    localparam int PW = $clog2(WR_CYCLES + 1);

    typedef enum logic [2:0] {
        DS_IDLE, DS_DEV, DS_WADDR, DS_WDATA, DS_HOLD, DS_READ, DS_PROG
    } twe_dst_e;

    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    twe_dst_e state_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic sda_low_r;
    logic rw_r;
    logic mack_r;
    logic wpend_r;
    logic [PW-1:0] prog_cnt_r;
    logic [twe_pkg::ADDR_W-1:0] addr_r;
    logic [twe_pkg::ADDR_W-1:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] mem_r [twe_pkg::WORDS];
    logic scl_hi, start_w, stop_w, rise_w, fall_w;
    logic ack_bit_w, ack_end_w, match_w, prog_done_w;
    logic [7:0] rd_byte;

    // two flops on each wire, the third only feeds edge detection
    always_ff @(posedge link_clk_i)
    begin
        if (!rst_n_i)
        begin
            scl_s1_r <= 1'h1;
            scl_s2_r <= 1'h1;
            scl_s3_r <= 1'h1;
            sda_s1_r <= 1'h1;
            sda_s2_r <= 1'h1;
            sda_s3_r <= 1'h1;
        end
        else if (ce_i)
        begin
            scl_s1_r <= link.scl;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    // bus events; data moving while the clock is high is a condition
    assign scl_hi = scl_s2_r & scl_s3_r;
    assign start_w = scl_hi & sda_s3_r & ~sda_s2_r;
    assign stop_w = scl_hi & ~sda_s3_r & sda_s2_r;
    assign rise_w = scl_s2_r & ~scl_s3_r;
    assign fall_w = ~scl_s2_r & scl_s3_r;
    assign ack_bit_w = fall_w & (cnt_r == twe_pkg::ACK_BIT);
    assign ack_end_w = fall_w & (cnt_r == twe_pkg::ACK_END);
    assign match_w = (sh_r[7:1] == twe_pkg::DEV_ID);
    assign prog_done_w = (prog_cnt_r == PW'(WR_CYCLES - 1));
    assign rd_byte = mem_r[addr_r];

    // protocol engine: bit count, shifter and data line pull
    always_ff @(posedge link_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= DS_IDLE;
            cnt_r <= twe_pkg::BIT_FIRST;
            sh_r <= 8'h00;
            sda_low_r <= 1'h0;
            rw_r <= 1'h0;
            mack_r <= 1'h0;
            wpend_r <= 1'h0;
            prog_cnt_r <= '0;
        end
        else if (ce_i)
        begin
            if (state_r == DS_PROG)
            begin
                // bus is deaf here, so polling sees no acknowledge
                sda_low_r <= 1'h0;
                prog_cnt_r <= prog_cnt_r + 1'h1;
                if (prog_done_w)
                begin
                    state_r <= DS_IDLE;
                    wpend_r <= 1'h0;
                end
            end
            else if (start_w)
            begin
                // a start in any state but DS_PROG drops a pending write
                state_r <= DS_DEV;
                cnt_r <= twe_pkg::BIT_FIRST;
                sda_low_r <= 1'h0;
                wpend_r <= 1'h0;
            end
            else if (stop_w)
            begin
                // only a fully acknowledged data byte is programmed
                state_r <= wpend_r ? DS_PROG : DS_IDLE;
                cnt_r <= twe_pkg::BIT_FIRST;
                sda_low_r <= 1'h0;
                prog_cnt_r <= '0;
            end
            else if (rise_w)
            begin
                // sample on the rising clock
                if (cnt_r < twe_pkg::ACK_BIT)
                    sh_r <= {sh_r[6:0], sda_s2_r};
                if (cnt_r == twe_pkg::ACK_BIT)
                    mack_r <= ~sda_s2_r;
                if (cnt_r != twe_pkg::ACK_END)
                    cnt_r <= cnt_r + 4'h1;
            end
            else if (fall_w)
            begin
                // all line changes happen after the falling clock
                case (state_r)
                    DS_DEV:
                    begin
                        if (ack_bit_w)
                        begin
                            if (match_w)
                            begin
                                sda_low_r <= 1'h1;
                                rw_r <= sh_r[0];
                            end
                            else
                                state_r <= DS_IDLE;
                        end
                        else if (ack_end_w)
                        begin
                            cnt_r <= twe_pkg::BIT_FIRST;
                            if (rw_r)
                            begin
                                state_r <= DS_READ;
                                sh_r <= rd_byte;
                                sda_low_r <= ~rd_byte[7];
                            end
                            else
                            begin
                                state_r <= DS_WADDR;
                                sda_low_r <= 1'h0;
                            end
                        end
                    end
                    DS_WADDR, DS_WDATA:
                    begin
                        if (ack_bit_w)
                            sda_low_r <= 1'h1;
                        else if (ack_end_w)
                        begin
                            sda_low_r <= 1'h0;
                            cnt_r <= twe_pkg::BIT_FIRST;
                            state_r <= (state_r == DS_WADDR) ? DS_WDATA : DS_HOLD;
                            wpend_r <= (state_r == DS_WDATA);
                        end
                    end
                    DS_READ:
                    begin
                        // the rising edge already shifted, so bit 7 is the next one out
                        if (cnt_r < twe_pkg::ACK_BIT)
                            sda_low_r <= ~sh_r[7];
                        else if (ack_bit_w)
                            sda_low_r <= 1'h0;
                        else if (mack_r)
                        begin
                            // master acknowledged: next byte follows
                            cnt_r <= twe_pkg::BIT_FIRST;
                            sh_r <= rd_byte;
                            sda_low_r <= ~rd_byte[7];
                        end
                        else
                            state_r <= DS_HOLD;
                    end
                    default:
                    begin
                        sda_low_r <= 1'h0;
                    end
                endcase
            end
        end
    end

    // word address counter; never reset by a stop, only by rst_n_i
    always_ff @(posedge link_clk_i)
    begin
        if (!rst_n_i)
        begin
            addr_r <= '0;
            wr_addr_r <= '0;
            wr_data_r <= 8'h00;
        end
        else if (ce_i && !start_w && !stop_w && state_r != DS_PROG)
        begin
            if (state_r == DS_WADDR && ack_bit_w)
                addr_r <= sh_r[twe_pkg::ADDR_W-1:0];
            else if (state_r == DS_WDATA && ack_bit_w)
            begin
                wr_addr_r <= addr_r;
                wr_data_r <= sh_r;
                // offset rolls inside the page
                addr_r <= {addr_r[twe_pkg::ADDR_W-1:PAGE_W],
                           addr_r[PAGE_W-1:0] + 1'h1};
            end
            else if (ack_end_w && ((state_r == DS_DEV && rw_r && match_w)
                     || (state_r == DS_READ && mack_r)))
                addr_r <= addr_r + 1'h1;
        end
    end

    // array is written once, at the end of the programming time
    always_ff @(posedge link_clk_i)
    begin
        if (ce_i && state_r == DS_PROG && prog_done_w)
            mem_r[wr_addr_r] <= wr_data_r;
    end

    // status flags
    always_ff @(posedge link_clk_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'h0;
            standby_o <= 1'h1;
        end
        else if (ce_i)
        begin
            busy_o <= (state_r == DS_PROG);
            standby_o <= (state_r == DS_IDLE);
        end
    end

    // open drain: the level driven is always low
    assign link.sda_d_o = 1'h0;
    assign link.sda_d_oe = sda_low_r;

endmodule // twe_dev

//--- twe_host.sv
/*
 * Host end of the two-wire link: makes the serial clock by a divider,
 * runs byte write, polling, current and random (sequential) reads.
 * Assumes one command at a time through the valid/ready handshake.
 */
`timescale 1ns/1ps
module twe_host #(
    parameter int QTR_CYC = twe_pkg::QTR_CYC
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // command
    input wire logic cmd_valid_i,
    input wire twe_pkg::twe_op_e cmd_op_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic [7:0] cmd_len_i,
    output logic cmd_ready_o,
    // answer
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic done_o,
    // serial bus
    twe_link_if.host link
);
    localparam int QW = $clog2(QTR_CYC + 1);

    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} twe_hst_e;
    typedef enum logic [2:0] {ST_DEVW, ST_WADDR, ST_DATA, ST_DEVR, ST_RD} twe_step_e;

    twe_hst_e state_r;
    twe_step_e step_r;
    twe_pkg::twe_op_e op_r;
    logic [QW-1:0] qcnt_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [7:0] tx_r, rx_r, addr_r, data_r, left_r;
    logic ackd_r, retry_r, scl_r, sda_low_r;
    logic sda_s1_r, sda_s2_r;
    logic tick_w;

    assign tick_w = (qcnt_r == QW'(QTR_CYC - 1));

    // data line comes back through two flops
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            sda_s1_r <= 1'h1;
            sda_s2_r <= 1'h1;
        end
        else if (ce_i)
        begin
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    // quarter-period divider, held while idle; frozen with the enable low
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            qcnt_r <= '0;
        else if (ce_i)
            qcnt_r <= (state_r == HS_IDLE || tick_w) ? '0 : qcnt_r + 1'h1;
    end

    // sequencer: start, bytes, stop; one phase per tick
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= HS_IDLE;
            step_r <= ST_DEVW;
            op_r <= twe_pkg::OP_WRITE;
            ph_r <= twe_pkg::PH_LOW;
            bit_r <= twe_pkg::BIT_FIRST;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            addr_r <= 8'h00;
            data_r <= 8'h00;
            left_r <= twe_pkg::ONE_BYTE;
            ackd_r <= 1'h0;
            retry_r <= 1'h0;
            scl_r <= 1'h1;
            sda_low_r <= 1'h0;
            cmd_ready_o <= 1'h0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'h0;
            done_o <= 1'h0;
        end
        else if (ce_i)
        begin
            rd_valid_o <= 1'h0;
            done_o <= 1'h0;
            case (state_r)
                HS_IDLE:
                begin
                    cmd_ready_o <= 1'h1;
                    if (cmd_valid_i && cmd_ready_o)
                    begin
                        // only start from an idle bus
                        cmd_ready_o <= 1'h0;
                        op_r <= cmd_op_i;
                        addr_r <= cmd_addr_i;
                        data_r <= cmd_data_i;
                        left_r <= (cmd_len_i == 8'h00) ? twe_pkg::ONE_BYTE : cmd_len_i;
                        step_r <= (cmd_op_i == twe_pkg::OP_CUR_RD) ? ST_DEVR : ST_DEVW;
                        ph_r <= twe_pkg::PH_LOW;
                        state_r <= HS_START;
                    end
                end
                HS_START:
                begin
                    if (tick_w)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            twe_pkg::PH_LOW: sda_low_r <= 1'h0;
                            twe_pkg::PH_RISE: scl_r <= 1'h1;
                            twe_pkg::PH_MID: sda_low_r <= 1'h1;
                            default:
                            begin
                                scl_r <= 1'h0;
                                bit_r <= twe_pkg::BIT_FIRST;
                                tx_r <= {twe_pkg::DEV_ID, step_r == ST_DEVR};
                                state_r <= HS_BYTE;
                            end
                        endcase
                    end
                end
                HS_BYTE:
                begin
                    if (tick_w)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            twe_pkg::PH_LOW:
                            begin
                                // data set only while the clock is low
                                if (bit_r < twe_pkg::ACK_BIT)
                                    sda_low_r <= (step_r != ST_RD) && !tx_r[7];
                                else
                                    sda_low_r <= (step_r == ST_RD)
                                                 && (left_r != twe_pkg::ONE_BYTE);
                            end
                            twe_pkg::PH_RISE: scl_r <= 1'h1;
                            twe_pkg::PH_MID:
                            begin
                                if (bit_r < twe_pkg::ACK_BIT)
                                begin
                                    rx_r <= {rx_r[6:0], sda_s2_r};
                                    tx_r <= {tx_r[6:0], 1'h0};
                                end
                                else
                                    ackd_r <= ~sda_s2_r;
                            end
                            default:
                            begin
                                scl_r <= 1'h0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == twe_pkg::ACK_BIT)
                                begin
                                    bit_r <= twe_pkg::BIT_FIRST;
                                    case (step_r)
                                        ST_DEVW, ST_DEVR:
                                        begin
                                            if (!ackd_r)
                                            begin
                                                // still programming: poll again
                                                retry_r <= 1'h1;
                                                state_r <= HS_STOP;
                                            end
                                            else if (step_r == ST_DEVR)
                                                step_r <= ST_RD;
                                            else if (op_r == twe_pkg::OP_POLL)
                                                state_r <= HS_STOP;
                                            else
                                            begin
                                                tx_r <= addr_r;
                                                step_r <= ST_WADDR;
                                            end
                                        end
                                        ST_WADDR:
                                        begin
                                            if (op_r == twe_pkg::OP_WRITE)
                                            begin
                                                tx_r <= data_r;
                                                step_r <= ST_DATA;
                                            end
                                            else
                                            begin
                                                // dummy write done, restart for read
                                                step_r <= ST_DEVR;
                                                state_r <= HS_START;
                                            end
                                        end
                                        ST_RD:
                                        begin
                                            rd_data_o <= rx_r;
                                            rd_valid_o <= 1'h1;
                                            left_r <= left_r - 8'h01;
                                            if (left_r == twe_pkg::ONE_BYTE)
                                                state_r <= HS_STOP;
                                        end
                                        default: state_r <= HS_STOP;
                                    endcase
                                end
                            end
                        endcase
                    end
                end
                default:
                begin
                    if (tick_w)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            twe_pkg::PH_LOW: sda_low_r <= 1'h1;
                            twe_pkg::PH_RISE: scl_r <= 1'h1;
                            twe_pkg::PH_MID: sda_low_r <= 1'h0;
                            default:
                            begin
                                retry_r <= 1'h0;
                                state_r <= retry_r ? HS_START : HS_IDLE;
                                done_o <= !retry_r;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // serial clock push-pull, data open drain
    assign link.scl = scl_r;
    assign link.sda_h_o = 1'h0;
    assign link.sda_h_oe = sda_low_r;

endmodule // twe_host

//--- twe_link_asserts.sv
/* checker for the two-wire link, watching only the wires.
   assumes the host clock and reset sample the bus. */
`timescale 1ns/1ps
module twe_link_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // link wires
    input wire logic scl,
    input wire logic sda_h_o,
    input wire logic sda_h_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic sda
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // open drain: a level of one would fight the pull-up
    dev_o_zero_a: assert property (sda_d_o == 1'b0)
        else $error("device data level not low");
    host_o_zero_a: assert property (sda_h_o == 1'b0)
        else $error("host data level not low");
    // memory changes its bit only while the clock is low
    dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
        else $error("device bit moved with clock high");
    ack_rise_low_a: assert property ($rose(sda_d_oe) |-> !scl [*4])
        else $error("device pull not inside clock low");
    ack_fall_low_a: assert property ($fell(sda_d_oe) |-> !scl)
        else $error("device release with clock high");
    // start made by the host alone, clock follows it down
    start_free_a: assert property (scl && $fell(sda) |-> !sda_d_oe)
        else $error("device pulling at start");
    start_clk_a: assert property (scl && $fell(sda) |-> ##[1:40] !scl)
        else $error("clock did not follow start");
    // each clock phase lasts at least a quarter period
    scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high too short");
    scl_low_min_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low too short");
endmodule // twe_link_asserts

//--- two_wire_serial_eeprom_slave_tb.sv
/* bench: host and memory end face each other over the link.
   assumes shortened quarter period and programming time. */
`timescale 1ns/1ps
module two_wire_serial_eeprom_slave_tb;
    logic sys_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid = 1'b0;
    twe_pkg::twe_op_e cmd_op = twe_pkg::OP_WRITE;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] cmd_len = 8'h00;
    logic cmd_ready, rd_valid, done, busy, standby, fin;
    logic [7:0] rd_data;
    logic [7:0] rq[$];
    int n_errors = 0;
    int total_checks = 0;
    twe_link_if link();
    // clocks unrelated in phase
    always #5 sys_clk_i = ~sys_clk_i;
    initial #2.3 forever #6 link_clk_i = ~link_clk_i;
    twe_host #(.QTR_CYC(8)) twe_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .cmd_len_i(cmd_len), .cmd_ready_o(cmd_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .done_o(done), .link(link.host));
    twe_dev #(.PAGE_W(3), .WR_CYCLES(20)) twe_dev_i (.link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .link(link.dev), .busy_o(busy), .standby_o(standby));
    twe_link_asserts twe_link_asserts_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl(link.scl),
        .sda_h_o(link.sda_h_o), .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o),
        .sda_d_oe(link.sda_d_oe), .sda(link.sda));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one command, read bytes gathered until done; host retries nacks itself
    task automatic run_cmd(input twe_pkg::twe_op_e op, input logic [7:0] a, d, n);
        int t;
        t = 0;
        rq.delete();
        fin = 1'b0;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_len = n;
        cmd_valid = 1'b1;
        do
            @(posedge sys_clk_i);
        while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        while (fin !== 1'b1 && t < 30000)
        begin
            @(posedge sys_clk_i);
            if (rd_valid === 1'b1)
                rq.push_back(rd_data);
            fin = done;
            t++;
        end
        check("command end", {7'h00, fin}, 8'h01);
        #1;
    endtask
    task automatic s_fill();
        logic [7:0] a [3] = '{8'h7F, 8'h00, 8'h01};
        for (int i = 0; i < 3; i++)
        begin
            run_cmd(twe_pkg::OP_WRITE, a[i], 8'h11 * 8'(i + 1), 8'h00);
            check("write done", {7'h00, fin}, 8'h01);
        end
        run_cmd(twe_pkg::OP_POLL, 8'h00, 8'h00, 8'h00);
        check("busy after poll", {7'h00, busy}, 8'h00);
    endtask
    task automatic s_page_wrap();
        run_cmd(twe_pkg::OP_WRITE, 8'h08, 8'h5A, 8'h00);
        run_cmd(twe_pkg::OP_WRITE, 8'h0F, 8'hA5, 8'h00);
        run_cmd(twe_pkg::OP_CUR_RD, 8'h00, 8'h00, 8'h00);
        check("page wrap byte", rq[0], 8'h5A);
    endtask
    task automatic s_seq_wrap();
        run_cmd(twe_pkg::OP_RND_RD, 8'h7F, 8'h00, 8'h03);
        check("byte count", 8'(rq.size()), 8'h03);
        for (int i = 0; i < 3; i++)
            check("sequential byte", rq[i], 8'h11 * 8'(i + 1));
        repeat (20) @(posedge sys_clk_i);
        check("standby", {7'h00, standby}, 8'h01);
    endtask
    task automatic s_random();
        run_cmd(twe_pkg::OP_RND_RD, 8'h0F, 8'h00, 8'h00);
        check("random byte", rq[0], 8'hA5);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short, well beyond the expected run
    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end
    // reset, then the scenarios in order
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1;
        s_fill();
        s_page_wrap();
        s_seq_wrap();
        s_random();
        stop_test();
    end
endmodule // two_wire_serial_eeprom_slave_tb
